// [design/vic_pkg.sv]
// vic_pkg: register map, field layout, reset values and vector table
// of the vectored interrupt controller.
// assumes a 32-bit apb master; byte address = 4 * register index.
`default_nettype none

package vic_pkg;

   // ********************************
   // sizes
   // ********************************
   localparam int          NSRC     = 9;
   localparam int          STAT_W   = 3;

   // ********************************
   // register indices
   // ********************************
   localparam logic [7:0]  IDX_ENA0 = 8'ha8;
   localparam logic [7:0]  IDX_LVH0 = 8'hb7;
   localparam logic [7:0]  IDX_LVL0 = 8'hb8;
   localparam logic [7:0]  IDX_ENA1 = 8'hb1;
   localparam logic [7:0]  IDX_LVL1 = 8'hb2;
   localparam logic [7:0]  IDX_LVH1 = 8'hb3;
   localparam logic [7:0]  IDX_STAT = 8'hc0;
   localparam logic [7:0]  IDX_MASK = 8'hc1;
   localparam logic [7:0]  IDX_SVC  = 8'hc2;

   // ********************************
   // fields and reset values
   // ********************************
   localparam int          BIT_GLOBAL = 7;
   localparam logic [7:0]  RST_REG0   = 8'h00;
   localparam logic [7:0]  RST_REG1   = 8'h00;
   localparam logic [7:0]  WMASK_LVL0 = 8'h7f;
   localparam logic [7:0]  WMASK_REG1 = 8'h05;
   localparam int          ST_ACCEPT  = 0;
   localparam int          ST_RETURN  = 1;
   localparam int          ST_ORPHAN  = 2;

   // ********************************
   // sources in polling order
   // ********************************
   localparam logic [3:0]  SRC_EXT0 = 4'h0;
   localparam logic [3:0]  SRC_TMR0 = 4'h1;
   localparam logic [3:0]  SRC_EXT1 = 4'h2;
   localparam logic [3:0]  SRC_TMR1 = 4'h3;
   localparam logic [3:0]  SRC_PCA  = 4'h4;
   localparam logic [3:0]  SRC_UART = 4'h5;
   localparam logic [3:0]  SRC_TMR2 = 4'h6;
   localparam logic [3:0]  SRC_KPD  = 4'h7;
   localparam logic [3:0]  SRC_SPI  = 4'h8;

   // ********************************
   // vector addresses
   // ********************************
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_EXT0  = 16'h0003;
   localparam logic [15:0] VEC_TMR0  = 16'h000b;
   localparam logic [15:0] VEC_EXT1  = 16'h0013;
   localparam logic [15:0] VEC_TMR1  = 16'h001b;
   localparam logic [15:0] VEC_UART  = 16'h0023;
   localparam logic [15:0] VEC_TMR2  = 16'h002b;
   localparam logic [15:0] VEC_PCA   = 16'h0033;
   localparam logic [15:0] VEC_KPD   = 16'h003b;
   localparam logic [15:0] VEC_SPARE = 16'h0043;
   localparam logic [15:0] VEC_SPI   = 16'h004b;

   typedef logic [1:0] vic_lvl_t;

endpackage

`default_nettype wire

// [design/vic_arb_if.sv]
// vic_arb_if: requests and levels to the arbiter, winner back.
// assumes one master and one arbiter, both purely combinational here.
`default_nettype none

interface vic_arb_if;
   import vic_pkg::*;
   logic [NSRC-1:0]           req;
   vic_lvl_t [NSRC-1:0]       lvl;
   logic                      win_valid;
   logic [3:0]                win_idx;
   vic_lvl_t                  win_lvl;

   modport mst (output req, lvl, input win_valid, win_idx, win_lvl);
   modport arb (input req, lvl, output win_valid, win_idx, win_lvl);
endinterface

`default_nettype wire

// [design/vic_arbiter.sv]
// vic_arbiter: picks the highest level, then the first in polling order.
// assumes requests are already gated by their enables.
`default_nettype none

module vic_arbiter
   import vic_pkg::*;
(
   // ********************************
   // request side
   // ********************************
   vic_arb_if.arb a
);

   // later assignments win: levels rise, indices fall
   always_comb begin
      a.win_valid = 1'b0;
      a.win_idx   = 4'h0;
      a.win_lvl   = 2'b00;
      for (int l = 0; l < 4; l++) begin
         for (int i = NSRC - 1; i >= 0; i--) begin
            // RQ5 higher level first
            // RQ6 fixed polling order
            if (a.req[i] && (a.lvl[i] == 2'(l))) begin
               a.win_valid = 1'b1;
               a.win_idx   = 4'(i);
               a.win_lvl   = 2'(l);
            end
         end
      end
   end

endmodule

`default_nettype wire

// [design/vic_top.sv]
// vic_top: vectored interrupt controller with apb registers.
// assumes sources hold their flags until cleared at the source, and the
// core pulses irq_ack to take a vector and irq_return on handler exit.
//
// Contract
// RQ1: nine sources are served, each with its own vector.
// RQ2: each source has its own enable, and the global enable blocks all.
// RQ3: a source's level is its high and low level bits, 00 lowest, 11 highest.
// RQ4: only a strictly higher level preempts, and level 3 is never preempted.
// RQ5: of requests arriving together, the higher level is served first.
// RQ6: equal levels go by ext0, tmr0, ext1, tmr1, pca, uart, tmr2, keypad, spi.
// RQ7: pca vectors to 0033h, keypad to 003bh and spi to 004bh.
// RQ8: reset vectors to 0000h, ext0 to 0003h and tmr0 to 000bh.
// RQ9: ext1 to 0013h, tmr1 to 001bh, uart 0023h, tmr2 002bh, 0043h unused.
// RQ10: uart, tmr2 and pca requests are the or of their several flags.
// RQ11: enable register 0 holds global at bit 7, sources at 6..0, resets 0.
// RQ12: level-low register 0 holds bits 6..0, bit 7 reserved, resets 0.
// RQ13: level-high register 0 uses the same bit order as level-low.
// RQ14: software writes no one to reserved bits and ignores their reads.
// RQ15: enable register 1 holds spi at bit 2 and keypad at bit 0.
// RQ16: level registers 1 hold spi at bit 2 and keypad at bit 0.
// RQ17: an accepted request presents its vector and is held in service.
//
// Our own choice: register access over APB.
`default_nettype none

module vic_top
   import vic_pkg::*;
(
   // ********************************
   // clock and reset
   // ********************************
   input  wire logic        pclk,
   input  wire logic        presetn,
   // ********************************
   // apb slave
   // ********************************
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // ********************************
   // source flags
   // ********************************
   input  wire logic        ext0_flag,
   input  wire logic        tmr0_ovf_flag,
   input  wire logic        ext1_flag,
   input  wire logic        tmr1_ovf_flag,
   input  wire logic        tmr2_ovf_flag,
   input  wire logic        tmr2_ext_flag,
   input  wire logic        uart_rx_flag,
   input  wire logic        uart_tx_flag,
   input  wire logic        pca_ovf_flag,
   input  wire logic [4:0]  pca_match_flags,
   input  wire logic        keypad_flag,
   input  wire logic        spi_flag,
   // ********************************
   // core side
   // ********************************
   output var  logic        irq_req,
   output var  logic [15:0] irq_vector,
   output var  logic [1:0]  irq_level,
   input  wire logic        irq_ack,
   input  wire logic        irq_return,
   // ********************************
   // summary interrupt
   // ********************************
   output var  logic        irq
);

   // ********************************
   // registers
   // ********************************
   logic [7:0]        irq_enable_reg0;
   logic [7:0]        lvl_low_reg0;
   logic [7:0]        lvl_high_reg0;
   logic [7:0]        irq_enable_reg1;
   logic [7:0]        lvl_low_reg1;
   logic [7:0]        lvl_high_reg1;
   logic [STAT_W-1:0] irq_status;
   logic [STAT_W-1:0] irq_mask;
   logic [3:0]        active;
   logic [3:0]        next_active;

   logic [7:0]        idx;
   logic              aligned;
   logic              mapped;
   logic              wr_en;
   logic              rd_done;
   logic [7:0]        rdata;

   logic [NSRC-1:0]   flags;
   logic [NSRC-1:0]   src_en;
   logic              grant_ok;
   logic              accept;
   logic [STAT_W-1:0] events;

   vic_arb_if arb_bus ();

   // ********************************
   // apb decode
   // ********************************
   assign idx     = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
   assign wr_en   = psel && penable && pwrite && mapped;
   assign rd_done = psel && penable && !pwrite && mapped;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_comb begin
      mapped = aligned;
      rdata  = 8'h00;
      unique case (idx)
         IDX_ENA0: rdata = irq_enable_reg0;
         IDX_LVH0: rdata = lvl_high_reg0;
         IDX_LVL0: rdata = lvl_low_reg0;
         IDX_ENA1: rdata = irq_enable_reg1;
         IDX_LVL1: rdata = lvl_low_reg1;
         IDX_LVH1: rdata = lvl_high_reg1;
         IDX_STAT: rdata = 8'(irq_status);
         IDX_MASK: rdata = 8'(irq_mask);
         IDX_SVC:  rdata = {4'h0, active};
         default:  mapped = 1'b0;
      endcase
   end

   // read data is captured in setup so the output comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata <= mapped ? {24'h00_0000, rdata} : 32'h0000_0000;
      end
   end

   // ********************************
   // control registers
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // RQ11 enable reset
         irq_enable_reg0 <= RST_REG0;
         // RQ12 level-low reset
         lvl_low_reg0    <= RST_REG0;
         lvl_high_reg0   <= RST_REG0;
         // RQ15 second enable reset
         irq_enable_reg1 <= RST_REG1;
         lvl_low_reg1    <= RST_REG1;
         lvl_high_reg1   <= RST_REG1;
         irq_mask        <= '0;
      end else if (wr_en) begin
         // reserved bits drop on write, so they always read zero
         unique case (idx)
            IDX_ENA0: irq_enable_reg0 <= pwdata[7:0];
            // RQ12 level-low layout
            IDX_LVL0: lvl_low_reg0    <= pwdata[7:0] & WMASK_LVL0;
            // RQ13 level-high layout
            IDX_LVH0: lvl_high_reg0   <= pwdata[7:0] & WMASK_LVL0;
            // RQ15 second enable
            IDX_ENA1: irq_enable_reg1 <= pwdata[7:0] & WMASK_REG1;
            // RQ16 second level pair
            IDX_LVL1: lvl_low_reg1    <= pwdata[7:0] & WMASK_REG1;
            IDX_LVH1: lvl_high_reg1   <= pwdata[7:0] & WMASK_REG1;
            IDX_MASK: irq_mask        <= pwdata[STAT_W-1:0];
            default: ;
         endcase
      end
   end

   // ********************************
   // source gathering
   // ********************************
   // RQ1 nine sources
   // RQ10 or-ed source flags
   assign flags = {spi_flag,
                   keypad_flag,
                   tmr2_ovf_flag | tmr2_ext_flag,
                   uart_rx_flag | uart_tx_flag,
                   pca_ovf_flag | (|pca_match_flags),
                   tmr1_ovf_flag,
                   ext1_flag,
                   tmr0_ovf_flag,
                   ext0_flag};

   // RQ11 enable bit order
   assign src_en = {irq_enable_reg1[2], irq_enable_reg1[0],
                    irq_enable_reg0[5], irq_enable_reg0[4],
                    irq_enable_reg0[6], irq_enable_reg0[3:0]};

   // RQ2 individual and global gating
   assign arb_bus.req = flags & src_en & {NSRC{irq_enable_reg0[BIT_GLOBAL]}};

   // RQ3 level from high and low bits
   always_comb begin
      arb_bus.lvl[SRC_EXT0] = {lvl_high_reg0[0], lvl_low_reg0[0]};
      arb_bus.lvl[SRC_TMR0] = {lvl_high_reg0[1], lvl_low_reg0[1]};
      arb_bus.lvl[SRC_EXT1] = {lvl_high_reg0[2], lvl_low_reg0[2]};
      arb_bus.lvl[SRC_TMR1] = {lvl_high_reg0[3], lvl_low_reg0[3]};
      arb_bus.lvl[SRC_UART] = {lvl_high_reg0[4], lvl_low_reg0[4]};
      arb_bus.lvl[SRC_TMR2] = {lvl_high_reg0[5], lvl_low_reg0[5]};
      arb_bus.lvl[SRC_PCA]  = {lvl_high_reg0[6], lvl_low_reg0[6]};
      // RQ16 keypad and spi levels
      arb_bus.lvl[SRC_KPD]  = {lvl_high_reg1[0], lvl_low_reg1[0]};
      arb_bus.lvl[SRC_SPI]  = {lvl_high_reg1[2], lvl_low_reg1[2]};
   end

   vic_arbiter u_arb (
      .a (arb_bus.arb)
   );

   // ********************************
   // vector table
   // ********************************
   function automatic logic [15:0] vec_of(input logic [3:0] s);
      unique case (s)
         // RQ8 ext0 and tmr0
         SRC_EXT0: vec_of = VEC_EXT0;
         SRC_TMR0: vec_of = VEC_TMR0;
         // RQ9 standard vectors
         SRC_EXT1: vec_of = VEC_EXT1;
         SRC_TMR1: vec_of = VEC_TMR1;
         SRC_UART: vec_of = VEC_UART;
         SRC_TMR2: vec_of = VEC_TMR2;
         // RQ7 added vectors
         SRC_PCA:  vec_of = VEC_PCA;
         SRC_KPD:  vec_of = VEC_KPD;
         SRC_SPI:  vec_of = VEC_SPI;
         default:  vec_of = VEC_SPARE;
      endcase
   endfunction

   // ********************************
   // preemption and service
   // ********************************
   // RQ4 strictly higher than every level in service
   assign grant_ok = arb_bus.win_valid && ((active >> arb_bus.win_lvl) == 4'h0);
   assign accept   = irq_req && irq_ack;

   always_comb begin
      next_active = active;
      // return retires the highest level in service
      if (irq_return) begin
         if (active[3]) begin
            next_active[3] = 1'b0;
         end else if (active[2]) begin
            next_active[2] = 1'b0;
         end else if (active[1]) begin
            next_active[1] = 1'b0;
         end else begin
            next_active[0] = 1'b0;
         end
      end
      if (accept) begin
         next_active[irq_level] = 1'b1;
      end
   end

   // RQ17 level held in service
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 4'h0;
      end else begin
         active <= next_active;
      end
   end

   // request drops for a cycle after ack or return so the new
   // in-service state is seen before the next offer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req    <= 1'b0;
         // RQ8 reset vector
         irq_vector <= VEC_RESET;
         irq_level  <= 2'b00;
      end else begin
         irq_req <= grant_ok && !irq_ack && !irq_return;
         // RQ17 present winning vector
         if (grant_ok && !accept) begin
            irq_vector <= vec_of(arb_bus.win_idx);
            irq_level  <= arb_bus.win_lvl;
         end
      end
   end

   // ********************************
   // status and summary interrupt
   // ********************************
   always_comb begin
      events            = '0;
      events[ST_ACCEPT] = accept;
      events[ST_RETURN] = irq_return && (active != 4'h0);
      events[ST_ORPHAN] = irq_return && (active == 4'h0);
   end

   // only bits shown in the captured read are cleared; set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else if (rd_done && (idx == IDX_STAT)) begin
         irq_status <= (irq_status & ~prdata[STAT_W-1:0]) | events;
      end else begin
         irq_status <= irq_status | events;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ********************************
   // assertions
   // ********************************
   logic higher_pending;

   always_comb begin
      higher_pending = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         if (arb_bus.req[i] && (arb_bus.lvl[i] > arb_bus.win_lvl)) begin
            higher_pending = 1'b1;
         end
      end
   end

   sequence s_accept;
      irq_req && irq_ack && !irq_return;
   endsequence

   sequence s_offer(logic [3:0] s);
      grant_ok && (arb_bus.win_idx == s) && !irq_ack && !irq_return;
   endsequence

   a_global_blocks_all: // RQ2
      assert property (@(posedge pclk) disable iff (!presetn)
         !irq_enable_reg0[BIT_GLOBAL] |=> !irq_req)
      else $error("request offered while global enable clear");

   a_strict_preempt: // RQ4
      assert property (@(posedge pclk) disable iff (!presetn)
         irq_req |-> ((active >> irq_level) == 4'h0))
      else $error("request does not outrank level in service");

   a_top_level_holds: // RQ4
      assert property (@(posedge pclk) disable iff (!presetn)
         active[3] [*2] |-> !irq_req)
      else $error("level 3 handler was offered a preemption");

   a_higher_first: // RQ5
      assert property (@(posedge pclk) disable iff (!presetn)
         arb_bus.win_valid |-> !higher_pending)
      else $error("lower level won over a higher one");

   a_poll_ext0_first: // RQ6
      assert property (@(posedge pclk) disable iff (!presetn)
         (arb_bus.req[SRC_EXT0] && arb_bus.req[SRC_TMR0]
          && (arb_bus.lvl[SRC_EXT0] == arb_bus.lvl[SRC_TMR0]))
         |-> (arb_bus.win_idx != SRC_TMR0))
      else $error("polling order broken at equal level");

   a_spi_vector: // RQ7
      assert property (@(posedge pclk) disable iff (!presetn)
         s_offer(SRC_SPI) |=> irq_req && (irq_vector == VEC_SPI))
      else $error("spi vector wrong");

   a_ext0_vector: // RQ8
      assert property (@(posedge pclk) disable iff (!presetn)
         s_offer(SRC_EXT0) |=> irq_req && (irq_vector == VEC_EXT0))
      else $error("ext0 vector wrong");

   a_uart_vector: // RQ9
      assert property (@(posedge pclk) disable iff (!presetn)
         s_offer(SRC_UART) |=> irq_req && (irq_vector == VEC_UART))
      else $error("uart vector wrong");

   a_uart_or_flags: // RQ10
      assert property (@(posedge pclk) disable iff (!presetn)
         (uart_tx_flag && irq_enable_reg0[4] && irq_enable_reg0[BIT_GLOBAL])
         |-> arb_bus.req[SRC_UART])
      else $error("uart transmit flag not requesting");

   a_service_record: // RQ17
      assert property (@(posedge pclk) disable iff (!presetn)
         s_accept |=> active[$past(irq_level)] && !irq_req)
      else $error("accepted level not held in service");

endmodule

`default_nettype wire

// [bench/vic_core_model.sv]
// vic_core_model: core side that takes offered vectors and returns.
// assumes vic_top offers irq_req, irq_vector and irq_level on pclk.
`default_nettype none

module vic_core_model (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // controller side
   input  wire logic        irq_req,
   input  wire logic [15:0] irq_vector,
   input  wire logic [1:0]  irq_level,
   output var  logic        irq_ack,
   output var  logic        irq_return,
   // bench control
   input  wire logic [2:0]  ack_wait,
   input  wire logic        ret_cmd,
   output var  logic [15:0] taken_vec,
   output var  logic [1:0]  taken_lvl,
   output var  int          taken_n
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] wait_cnt;

   // a slow core leaves the offer standing; it must survive the stall
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ack    <= 1'b0;
         irq_return <= 1'b0;
         wait_cnt   <= 3'h0;
         taken_vec  <= 16'h0;
         taken_lvl  <= 2'h0;
         taken_n    <= 0;
      end else begin
         irq_ack    <= 1'b0;
         irq_return <= ret_cmd;
         if (irq_ack) begin
            taken_vec <= irq_vector;
            taken_lvl <= irq_level;
            taken_n   <= taken_n + 1;
            wait_cnt  <= 3'h0;
         end else if (!irq_req) begin
            wait_cnt <= 3'h0;
         end else if (wait_cnt == ack_wait) begin
            irq_ack <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 3'h1;
         end
      end
   end
endmodule

`default_nettype wire

// [bench/vic_top_tb.sv]
// vic_top_tb: apb register tests and interrupt scenarios for vic_top.
// assumes vic_core_model as the core; apb answers are polled on pready.
`default_nettype none

module vic_top_tb;
   import vic_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] fl, irq_vector, tvec;
   logic        irq_req, irq_ack, irq_return, irq, ret_cmd;
   logic [1:0]  irq_level, tlvl;
   logic [2:0]  ack_wait;
   int          taken_n, fails, checks_done;
   logic [31:0] rv;
   logic        er;
   logic [7:0]  ridx [6] = '{IDX_ENA0, IDX_LVH0, IDX_LVL0, IDX_ENA1, IDX_LVL1, IDX_LVH1};
   logic [7:0]  rval [6] = '{8'hff, 8'h7f, 8'h7f, 8'h05, 8'h05, 8'h05};
   logic [15:0] ordv [9] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033,
                             16'h0023, 16'h002b, 16'h003b, 16'h004b};
   logic [15:0] ordm [9] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h3f00,
                             16'h00c0, 16'h0030, 16'h4000, 16'h8000};

   vic_top u_vic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext0_flag(fl[0]), .tmr0_ovf_flag(fl[1]), .ext1_flag(fl[2]),
      .tmr1_ovf_flag(fl[3]), .tmr2_ovf_flag(fl[4]), .tmr2_ext_flag(fl[5]),
      .uart_rx_flag(fl[6]), .uart_tx_flag(fl[7]), .pca_ovf_flag(fl[8]),
      .pca_match_flags(fl[13:9]), .keypad_flag(fl[14]), .spi_flag(fl[15]),
      .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
      .irq_ack(irq_ack), .irq_return(irq_return), .irq(irq));

   vic_core_model u_vic_core_model (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
      .irq_vector(irq_vector), .irq_level(irq_level), .irq_ack(irq_ack),
      .irq_return(irq_return), .ack_wait(ack_wait), .ret_cmd(ret_cmd),
      .taken_vec(tvec), .taken_lvl(tlvl), .taken_n(taken_n));

   always #5 pclk = ~pclk;

   // ****
   // tasks
   // ****
   task automatic stop_test;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                      input logic [1:0] off = 2'b00);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, off};
      pwdata  <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      apb(idx, 1'b0, 8'h00);
      chk("slverr", 32'h0, 32'(er));
      chk($sformatf("reg %h", idx), e, rv);
   endtask

   // waits for the core to take a vector, bounded
   task automatic take(input logic [15:0] v, input logic [1:0] l);
      int n0;
      int k;
      n0 = taken_n;
      k = 0;
      while (taken_n == n0 && k < 60) begin
         @(posedge pclk);
         k++;
      end
      chk("accepted", 32'h1, 32'(k < 60));
      chk("vector", 32'(v), 32'(tvec));
      chk("level", 32'(l), 32'(tlvl));
   endtask

   task automatic none;
      int n0;
      n0 = taken_n;
      repeat (16) @(posedge pclk);
      chk("no accept", n0, taken_n);
   endtask

   task automatic ret;
      ret_cmd <= 1'b1;
      @(posedge pclk);
      ret_cmd <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic [15:0] vexp(input int i);
      case (i)
         0: return 16'h0003;
         1: return 16'h000b;
         2: return 16'h0013;
         3: return 16'h001b;
         4, 5: return 16'h002b;
         6, 7: return 16'h0023;
         14: return 16'h003b;
         15: return 16'h004b;
         default: return 16'h0033;
      endcase
   endfunction

   // ****
   // watchdog
   // ****
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      stop_test;
   end

   // ****
   // tests
   // ****
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; fl = '0; ret_cmd = 0; ack_wait = 3'h0; fails = 0; checks_done = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("reset vector", 32'h0, 32'(irq_vector));
      chk("pready", 32'h1, 32'(pready));
      chk("reset irq", 32'h0, 32'({irq_req, irq}));
      for (int i = 0; i < 6; i++) rd(ridx[i], 32'h0);
      // reserved bits are always written as zero
      for (int i = 0; i < 6; i++) apb(ridx[i], 1'b1, rval[i]);
      for (int i = 0; i < 6; i++) rd(ridx[i], 32'(rval[i]));
      apb(8'h00, 1'b0, 8'h00);
      chk("slverr", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rv);
      // misaligned write is refused and leaves the register alone
      apb(IDX_ENA0, 1'b1, 8'h00, 2'b01);
      chk("misaligned slverr", 32'h1, 32'(er));
      rd(IDX_ENA0, 32'hff);
      for (int i = 1; i < 6; i++) if (i != 3) apb(ridx[i], 1'b1, 8'h00);
      apb(IDX_ENA0, 1'b1, 8'h7f);
      fl <= 16'h0001;
      none();
      chk("irq_req", 32'h0, 32'(irq_req));
      apb(IDX_ENA0, 1'b1, 8'h80);
      none();
      apb(IDX_ENA0, 1'b1, 8'hff);
      take(16'h0003, 2'd0);
      fl <= 16'h0;
      ret();
      for (int i = 0; i < 16; i++) begin
         ack_wait <= 3'(i);
         fl <= 16'h1 << i;
         take(vexp(i), 2'd0);
         fl <= 16'h0;
         ret();
      end
      ack_wait <= 3'h0;
      fl <= 16'hffff;
      for (int k = 0; k < 9; k++) begin
         take(ordv[k], 2'd0);
         fl <= fl & ~ordm[k];
         ret();
      end
      // spi and keypad at 3, uart 2, tmr1 1, ext0 0
      apb(IDX_LVH1, 1'b1, 8'h05);
      apb(IDX_LVL1, 1'b1, 8'h05);
      apb(IDX_LVH0, 1'b1, 8'h10);
      apb(IDX_LVL0, 1'b1, 8'h08);
      fl <= 16'h8049;
      take(16'h004b, 2'd3);
      fl <= fl | 16'h4000;
      none();
      fl <= fl & ~16'h8000;
      ret();
      take(16'h003b, 2'd3);
      fl <= fl & ~16'h4000;
      ret();
      take(16'h0023, 2'd2);
      fl <= fl & ~16'h0040;
      ret();
      take(16'h001b, 2'd1);
      fl <= fl | 16'h8000;
      take(16'h004b, 2'd3);
      fl <= fl & ~16'h8000;
      ret();
      none();
      fl <= fl & ~16'h0008;
      ret();
      take(16'h0003, 2'd0);
      fl <= fl | 16'h0004;
      none();
      fl <= fl & ~16'h0001;
      ret();
      take(16'h0013, 2'd0);
      fl <= 16'h0;
      ret();
      // status, mask and summary interrupt
      apb(IDX_STAT, 1'b0, 8'h00);
      apb(IDX_MASK, 1'b1, 8'h00);
      fl <= 16'h0001;
      take(16'h0003, 2'd0);
      chk("irq masked", 32'h0, 32'(irq));
      apb(IDX_MASK, 1'b1, 8'h07);
      chk("irq", 32'h1, 32'(irq));
      rd(IDX_SVC, 32'h1);
      rd(IDX_STAT, 32'h1);
      chk("irq cleared", 32'h0, 32'(irq));
      fl <= 16'h0;
      ret();
      rd(IDX_STAT, 32'h2);
      ret();
      apb(IDX_STAT, 1'b0, 8'h00);
      chk("orphan return", 32'h1, 32'(rv[2]));
      stop_test;
   end
endmodule

`default_nettype wire
